// >>> hdl/host_ctrl_two_defs.vh
// Constants for the second host control register block.
// Included by the block's design file only.
`ifndef HOST_CTRL_TWO_DEFS_VH
`define HOST_CTRL_TWO_DEFS_VH
// Byte addresses (printed offset 0x3E is not word aligned: index * 4)
`define HC2_IDX            8'h3E
`define HC2_ADDR           10'h0F8
`define CLKCTL_ADDR        10'h100
`define PRESET_ADDR        10'h104
`define CAPS_ADDR          10'h108
`define STATUS_ADDR        10'h10C
`define MASK_ADDR          10'h110
`define LINK_ADDR          10'h114
// Field positions
`define PRESET_EN_BIT      15
`define ASYNC_EN_BIT       14
`define HC2_RESET          16'h0000
// Status bits
`define ST_CARD_IRQ        0
`define ST_ASYNC_IRQ       1
`define ST_PRESET_CHG      2
`define STATUS_W           3
// Card clock idle count before the clock is deemed stopped
`define CLK_IDLE_MAX       4'hF
`endif

// >>> hdl/sd_host_ctrl2.v
// Second host control register of an SD host, SD/SDIO layout, with
// preset clock selection and asynchronous card interrupt forwarding.
// Assumes an AHB-Lite master; card clock and DAT1 arrive asynchronously.
//
// Notes on behaviour
// - Bit 15 preset enable, bit 14 async enable
// - Preset off: software clock selects used
// - Preset on: table sets clock and drive
// - Async only for DAT1 in 4-bit mode
// - Card interrupt forwarded while clock stopped
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "host_ctrl_two_defs.vh"

module sd_host_ctrl2 #(
  parameter DIV_W        = 10,
  parameter GEN_W        = 1,
  parameter DRV_W        = 2,
  parameter ASYNC_SUPP   = 1'b1
) (
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  input  wire              sd_clk_in,
  input  wire              dat1_in,
  input  wire              bus_4bit,
  output reg               card_irq,
  output reg               irq,
  output reg  [DIV_W-1:0]  card_clock_divider_select,
  output reg  [GEN_W-1:0]  clock_generator_select,
  output reg  [DRV_W-1:0]  driver_strength_select,
  output reg               clock_stopped
);

  // Control and software registers
  reg                      preset_select_enable;
  reg                      async_card_irq_enable;
  reg [DIV_W-1:0]          sw_divider;
  reg [GEN_W-1:0]          sw_gen;
  reg                      sw_clk_enable;
  reg [DRV_W-1:0]          sw_drive;
  reg [DIV_W-1:0]          pv_divider;
  reg [GEN_W-1:0]          pv_gen;
  reg [DRV_W-1:0]          pv_drive;
  reg [`STATUS_W-1:0]      status;
  reg [`STATUS_W-1:0]      mask;

  // Bus data phase state
  reg                      dp_valid;
  reg                      dp_write;
  reg [9:0]                dp_addr;

  // Synchronisers for pins
  reg                      dat1_s1;
  reg                      dat1_s2;
  reg                      clk_s1;
  reg                      clk_s2;
  reg                      clk_s3;
  reg                      mode_s1;
  reg                      mode_s2;
  reg                      dat1_q;
  reg [3:0]                idle_cnt;

  wire                     addr_phase;
  wire                     wr_now;
  wire                     rd_now;
  wire                     clk_edge;
  wire                     irq_line;
  wire                     irq_rise;
  wire [15:0]              hc2_value;
  reg  [31:0]              next_rdata;
  reg  [`STATUS_W-1:0]     ev;
  wire                     hc2_wr;
  wire                     clkctl_wr;
  wire                     preset_wr;
  wire                     mask_wr;

  function [31:0] zext16;
    input [15:0] v;
    begin
      zext16 = {16'h0000, v};
    end
  endfunction

  // Pack the clock control layout into a bus word
  function [31:0] clk_word;
    input             en;
    input [DRV_W-1:0] drive;
    input [GEN_W-1:0] gen;
    input [DIV_W-1:0] div;
    begin
      clk_word = {15'h0000, en, drive,
                  {(16-DRV_W-GEN_W-DIV_W){1'b0}}, gen, div};
    end
  endfunction

  assign addr_phase = hsel & hready & htrans[1];
  assign wr_now     = dp_valid & dp_write;
  assign rd_now     = addr_phase & ~hwrite;

  // Writes finishing this cycle, forwarded to a read right behind them
  assign hc2_wr    = wr_now & (dp_addr == `HC2_ADDR);
  assign clkctl_wr = wr_now & (dp_addr == `CLKCTL_ADDR);
  assign preset_wr = wr_now & (dp_addr == `PRESET_ADDR);
  assign mask_wr   = wr_now & (dp_addr == `MASK_ADDR);

  // Only bits 15 and 14 exist; the rest read zero
  assign hc2_value = {preset_select_enable, async_card_irq_enable,
                      14'h0000};

  // Address phase capture, zero wait state slave
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= 10'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_valid  <= addr_phase;
      dp_write  <= hwrite;
      dp_addr   <= haddr[9:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read mux, registered onto hrdata for the data phase
  always @* begin
    next_rdata = 32'h00000000;
    case (haddr[9:0])
      `HC2_ADDR:    next_rdata = hc2_wr ?
                      zext16({hwdata[`PRESET_EN_BIT], hwdata[`ASYNC_EN_BIT],
                              14'h0000}) :
                      zext16(hc2_value);
      `CLKCTL_ADDR: next_rdata = clkctl_wr ?
                      clk_word(hwdata[16], hwdata[15:14],
                               hwdata[DIV_W+GEN_W-1:DIV_W],
                               hwdata[DIV_W-1:0]) :
                      clk_word(sw_clk_enable, sw_drive, sw_gen, sw_divider);
      `PRESET_ADDR: next_rdata = preset_wr ?
                      clk_word(1'b0, hwdata[15:14],
                               hwdata[DIV_W+GEN_W-1:DIV_W],
                               hwdata[DIV_W-1:0]) :
                      clk_word(1'b0, pv_drive, pv_gen, pv_divider);
      `CAPS_ADDR:   next_rdata = {31'h00000000, ASYNC_SUPP};
      `STATUS_ADDR: next_rdata = {29'h00000000, status};
      `MASK_ADDR:   next_rdata = {29'h00000000,
                                  mask_wr ? hwdata[`STATUS_W-1:0] : mask};
      `LINK_ADDR:   next_rdata = {29'h00000000, clock_stopped,
                                  mode_s2, dat1_q};
      default:      next_rdata = 32'h00000000;
    endcase
  end

  // Read data launched at the address phase edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_now) begin
      hrdata <= next_rdata;
    end
  end

  // Register writes; bits 13..0 of the control register are dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preset_select_enable  <= 1'b0;
      async_card_irq_enable <= 1'b0;
      sw_divider            <= {DIV_W{1'b0}};
      sw_gen                <= {GEN_W{1'b0}};
      sw_drive              <= {DRV_W{1'b0}};
      sw_clk_enable         <= 1'b0;
      pv_divider            <= {DIV_W{1'b0}};
      pv_gen                <= {GEN_W{1'b0}};
      pv_drive              <= {DRV_W{1'b0}};
      mask                  <= {`STATUS_W{1'b0}};
    end else if (wr_now) begin
      case (dp_addr)
        `HC2_ADDR: begin
          preset_select_enable  <= hwdata[`PRESET_EN_BIT];
          async_card_irq_enable <= hwdata[`ASYNC_EN_BIT];
        end
        `CLKCTL_ADDR: begin
          sw_divider    <= hwdata[DIV_W-1:0];
          sw_gen        <= hwdata[DIV_W+GEN_W-1:DIV_W];
          sw_drive      <= hwdata[15:14];
          sw_clk_enable <= hwdata[16];
        end
        `PRESET_ADDR: begin
          pv_divider <= hwdata[DIV_W-1:0];
          pv_gen     <= hwdata[DIV_W+GEN_W-1:DIV_W];
          pv_drive   <= hwdata[15:14];
        end
        `MASK_ADDR: mask <= hwdata[`STATUS_W-1:0];
        default: ;
      endcase
    end
  end

  // Clock selection source: software or preset table
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_clock_divider_select <= {DIV_W{1'b0}};
      clock_generator_select    <= {GEN_W{1'b0}};
      driver_strength_select    <= {DRV_W{1'b0}};
    end else if (preset_select_enable) begin
      card_clock_divider_select <= pv_divider;
      clock_generator_select    <= pv_gen;
      driver_strength_select    <= pv_drive;
    end else begin
      card_clock_divider_select <= sw_divider;
      clock_generator_select    <= sw_gen;
      driver_strength_select    <= sw_drive;
    end
  end

  // Two-stage synchronisers for card pins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dat1_s1 <= 1'b1;
      dat1_s2 <= 1'b1;
      clk_s1  <= 1'b0;
      clk_s2  <= 1'b0;
      clk_s3  <= 1'b0;
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
      dat1_q  <= 1'b1;
    end else begin
      dat1_s1 <= dat1_in;
      dat1_s2 <= dat1_s1;
      clk_s1  <= sd_clk_in;
      clk_s2  <= clk_s1;
      clk_s3  <= clk_s2;
      mode_s1 <= bus_4bit;
      mode_s2 <= mode_s1;
      dat1_q  <= dat1_s2;
    end
  end

  assign clk_edge = clk_s2 & ~clk_s3;

  // Card clock considered stopped after idle hclk cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt      <= 4'h0;
      clock_stopped <= 1'b1;
    end else if (clk_edge) begin
      idle_cnt      <= 4'h0;
      clock_stopped <= 1'b0;
    end else if (idle_cnt != `CLK_IDLE_MAX) begin
      idle_cnt <= idle_cnt + 4'h1;
    end else begin
      clock_stopped <= 1'b1;
    end
  end

  // Card interrupt: DAT1 low in 4-bit mode; when the clock is stopped
  // only the async path may deliver it
  assign irq_line = mode_s2 & ~dat1_s2 &
                    (~clock_stopped | async_card_irq_enable);
  assign irq_rise = irq_line & ~card_irq;

  // Forwarded card interrupt level
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_irq <= 1'b0;
    end else begin
      card_irq <= irq_line;
    end
  end

  // Events for the sticky status register
  always @* begin
    ev = {`STATUS_W{1'b0}};
    ev[`ST_CARD_IRQ]   = irq_rise;
    ev[`ST_ASYNC_IRQ]  = irq_rise & clock_stopped;
    ev[`ST_PRESET_CHG] = hc2_wr &
                         (hwdata[`PRESET_EN_BIT] != preset_select_enable);
  end

  // Sticky status, cleared at the edge that captures it for a read,
  // so no event slips in between; a new event wins over the clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= {`STATUS_W{1'b0}};
    end else if (rd_now && haddr[9:0] == `STATUS_ADDR) begin
      status <= ev;
    end else begin
      status <= status | ev;
    end
  end

  // Level interrupt from unmasked status bits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

endmodule // sd_host_ctrl2

// >>> tb/sd_card_model.sv
// Card side model: card clock pin and DAT1 line with its pull-up.
// Assumes the bench starts and stops the clock and requests interrupts.
`timescale 1ns/1ps
module sd_card_model (
  input  wire logic run_clk,
  input  wire logic irq_req,
  output logic      sd_clk,
  output wire logic dat1
);
  // Card clock, 160 ns, stands low outside a frame
  initial begin
    sd_clk = 1'b0;
    #7;
    forever #80 sd_clk = run_clk ? ~sd_clk : 1'b0;
  end
  // Card pulls DAT1 low to interrupt, pull-up otherwise
  assign dat1 = irq_req ? 1'b0 : 1'b1;
endmodule // sd_card_model

// >>> tb/sd_host_ctrl2_checker.sv
// Checker for the second host control register block, bound to its top.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
module sd_host_ctrl2_checker #(
  parameter DIV_W = 10,
  parameter GEN_W = 1,
  parameter DRV_W = 2
) (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic             dat1_in,
  input wire logic             bus_4bit,
  input wire logic             card_irq,
  input wire logic [DIV_W-1:0] card_clock_divider_select,
  input wire logic [GEN_W-1:0] clock_generator_select,
  input wire logic [DRV_W-1:0] driver_strength_select,
  input wire logic             clock_stopped
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Control word shows only its two live bits
  a_ctl_read_zero: assert property (
    hsel && hready && htrans[1] && !hwrite && haddr[9:0] == 10'h0F8
    |=> hrdata[31:16] == 16'h0000 && hrdata[13:0] == 14'h0000)
    else $error("control word low bits not zero");
  // Selects move only after a register write
  a_selects_hold: assert property (
    (!(hsel && htrans[1] && hwrite)) [*4] |=>
    $stable(card_clock_divider_select) && $stable(clock_generator_select)
    && $stable(driver_strength_select))
    else $error("clock selects changed without a write");
  // No forwarding outside 4-bit mode
  a_narrow_quiet: assert property (
    (!bus_4bit) [*8] |-> !card_irq)
    else $error("card interrupt outside 4-bit mode");
  // No forwarding while DAT1 is high
  a_dat1_quiet: assert property (
    dat1_in [*8] |-> !card_irq)
    else $error("card interrupt with DAT1 high");
  // Running clock in 4-bit mode always forwards the card interrupt
  a_running_fwd: assert property (
    (bus_4bit && !dat1_in && !clock_stopped) [*8] |-> card_irq)
    else $error("card interrupt not forwarded");
  // Zero wait states, always OKAY
  a_ready_okay: assert property (
    hreadyout && !hresp)
    else $error("slave stalled or answered with error");
endmodule // sd_host_ctrl2_checker

// >>> tb/test_sd_host_ctrl2_clock_preset_async_irq.sv
// Bench for the second host control register block, software side.
// Assumes the card model drives the card clock and DAT1 pins.
`timescale 1ns/1ps
module test_sd_host_ctrl2_clock_preset_async_irq;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, drv;
  logic [2:0]  hsize;
  logic [9:0]  div;
  logic [0:0]  gen;
  logic        bus_4bit, run_clk, irq_req, sd_clk, dat1;
  logic        card_irq, irq, stopped;
  int          mismatches, check_count, cycles;
  assign hready = hreadyout;
  sd_host_ctrl2 dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .sd_clk_in(sd_clk),
    .dat1_in(dat1), .bus_4bit, .card_irq, .irq,
    .card_clock_divider_select(div), .clock_generator_select(gen),
    .driver_strength_select(drv), .clock_stopped(stopped));
  sd_card_model card (.run_clk, .irq_req, .sd_clk, .dat1);
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One AHB-Lite single word transfer, entered at a clock edge
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // Write then read of one register, back to back
  task automatic bus_pair(input logic [9:0] a, input logic [31:0] d,
                          output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= {22'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hwrite <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic t_reset;
    chk({div, gen, drv, stopped}, 32'h1);
    bus(1'b0, 10'h0F8, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, 10'h3FC, 32'h0, q);
    chk(q, 32'h0);
  endtask
  task automatic t_ctl;
    bus(1'b1, 10'h0F8, 32'hFFFFFFFF, q);
    bus(1'b0, 10'h0F8, 32'h0, q);
    chk(q, 32'hC000);
    bus(1'b1, 10'h0F8, 32'h3FFF, q);
    bus(1'b0, 10'h0F8, 32'h0, q);
    chk(q, 32'h0);
    bus_pair(10'h0F8, 32'h4000, q);
    chk(q, 32'h4000);
  endtask
  task automatic t_sel;
    bus(1'b1, 10'h100, 32'h18555, q);
    bus(1'b1, 10'h104, 32'h42AA, q);
    repeat (2) @(posedge hclk);
    chk({div, gen, drv}, 32'hAAE);
    bus(1'b1, 10'h110, 32'h4, q);
    bus(1'b1, 10'h0F8, 32'h8000, q);
    repeat (2) @(posedge hclk);
    chk({div, gen, drv}, 32'h1551);
    chk(irq, 1'b1);
    bus(1'b0, 10'h10C, 32'h0, q);
    chk(q, 32'h4);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    bus(1'b1, 10'h0F8, 32'h0, q);
    repeat (2) @(posedge hclk);
    chk({div, gen, drv}, 32'hAAE);
  endtask
  task automatic t_link;
    bus(1'b0, 10'h108, 32'h0, q);
    chk(q & 32'h1, 32'h1);
    bus(1'b1, 10'h0F8, 32'h4000, q);
    run_clk <= 1'b1;
    irq_req <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({stopped, card_irq}, 32'h0);
    bus_4bit <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(card_irq, 1'b1);
    irq_req <= 1'b0;
    repeat (10) @(posedge hclk);
    chk(card_irq, 1'b0);
    run_clk <= 1'b0;
    repeat (40) @(posedge hclk);
    irq_req <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({stopped, card_irq}, 32'h3);
    bus(1'b0, 10'h114, 32'h0, q);
    chk(q, 32'h6);
    bus(1'b0, 10'h10C, 32'h0, q);
    chk(q & 32'h2, 32'h2);
  endtask
  // Clock, 50 MHz
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Cut a hang short
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      results;
    end
  end
  // Reset, then the scenarios
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bus_4bit = 1'b0;
    run_clk = 1'b0;
    irq_req = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_ctl;
    t_sel;
    t_link;
    results;
  end
endmodule // test_sd_host_ctrl2_clock_preset_async_irq
bind sd_host_ctrl2 sd_host_ctrl2_checker #(
  .DIV_W(DIV_W), .GEN_W(GEN_W), .DRV_W(DRV_W)) checker_i (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .dat1_in, .bus_4bit, .card_irq,
  .card_clock_divider_select, .clock_generator_select,
  .driver_strength_select, .clock_stopped);
